// [logic/step_dir_input.sv]
// Purpose: Top of the step/direction command front end with Avalon-MM registers
// Assumes: Pins synchronous enough to be sampled through a two-stage synchroniser
// Notes:   Every top output is a flip-flop
//
// Contract
// - Every rising or falling step edge advances one microstep.
// - Direction level selects rotation sense for following steps.
// - Motion only while enabled; disabled drops steps and the driver.
// - Unconnected enable input behaves as enabled.
// - Optional idle mode lowers current setpoint to 60 percent when stopped.
// - Sixteen resolutions, finest 51200 per rev, increment follows selection.
`timescale 1ns/1ns
`default_nettype none
module step_dir_input #(
  parameter logic [31:0] IDLE_DELAY = 32'(step_pkg::IDLE_DELAY_CYC)
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // Command pins
  input  wire logic        STEP_PULSE_IN,
  input  wire logic        DIR_IN,
  input  wire logic        DRIVE_ENABLE_IN_N,
  // Avalon-MM slave
  input  wire logic [3:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST,
  // Drive status
  output logic             DRIVER_ON,
  output logic [7:0]       CURRENT_SET,
  output logic [31:0]      POSITION
);

  step_if ev ();

  logic [31:0]                ctrl_reg;
  logic [31:0]                ctrl_next;
  logic [7:0]                 run_cur_reg;
  logic [7:0]                 run_cur_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic                       wait_reg;
  logic                       wait_next;
  step_pkg::bus_state_t       bus_reg;
  step_pkg::bus_state_t       bus_next;
  logic                       on_reg;
  logic                       on_next;
  logic [7:0]                 cur_out_reg;
  logic [7:0]                 cur_out_next;
  logic [31:0]                pos_out_reg;
  logic [31:0]                pos_out_next;
  logic [step_pkg::POS_W-1:0] position;
  logic [7:0]                 current_set;
  logic                       driver_on;
  logic                       idle_active;
  logic [31:0]                step_count;

  // ----------------------------------------------------------------
  // Pin stage and position core
  // ----------------------------------------------------------------
  step_input_sync u_sync (
    .clk          (CLOCK),
    .rst_n        (RSTN),
    .step_pin     (STEP_PULSE_IN),
    .dir_pin      (DIR_IN),
    .enable_n_pin (DRIVE_ENABLE_IN_N),
    .ev           (ev.source)
  );

  step_position u_pos (
    .clk            (CLOCK),
    .rst_n          (RSTN),
    .ev             (ev.sink),
    .sw_enable      (ctrl_reg[step_pkg::CTRL_EN_BIT]),
    .idle_mode      (ctrl_reg[step_pkg::CTRL_IDLE_BIT]),
    .res_sel        (ctrl_reg[step_pkg::CTRL_RES_LSB +: 4]),
    .run_current    (run_cur_reg),
    .idle_delay_cyc (IDLE_DELAY),
    .position       (position),
    .current_set    (current_set),
    .driver_on      (driver_on),
    .idle_active    (idle_active),
    .step_count     (step_count)
  );

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Waitrequest idles high; one cycle low acknowledges each request
  always_comb begin
    bus_next     = bus_reg;
    wait_next    = 1'b1;
    rdata_next   = rdata_reg;
    ctrl_next    = ctrl_reg;
    run_cur_next = run_cur_reg;
    case (bus_reg)
      step_pkg::BUS_IDLE: begin
        if (READ || WRITE) begin
          bus_next  = step_pkg::BUS_ACK;
          wait_next = 1'b0;
          if (READ) begin
            if (ADDRESS == step_pkg::CTRL_OFS)
              rdata_next = ctrl_reg;
            else if (ADDRESS == step_pkg::STATUS_OFS)
              rdata_next = {29'h0, idle_active, ev.dir_level, driver_on};
            else if (ADDRESS == step_pkg::POS_OFS)
              rdata_next = position;
            else if (ADDRESS == step_pkg::CURRENT_OFS)
              rdata_next = {16'h0, current_set, run_cur_reg};
            else
              rdata_next = step_pkg::UNMAPPED_DATA;
          end
        end
      end
      step_pkg::BUS_ACK: begin
        bus_next = step_pkg::BUS_DONE;
        // Writes land at the edge where the master sees waitrequest low
        if (WRITE) begin
          if (ADDRESS == step_pkg::CTRL_OFS)
            ctrl_next = merge(ctrl_reg, WRITEDATA, BYTEENABLE) & 32'h0000_00f3;
          else if (ADDRESS == step_pkg::CURRENT_OFS && BYTEENABLE[0])
            run_cur_next = WRITEDATA[7:0];
        end
      end
      step_pkg::BUS_DONE: begin
        bus_next = step_pkg::BUS_IDLE;
      end
      default: begin
        bus_next = step_pkg::BUS_IDLE;
      end
    endcase
    on_next      = driver_on;
    cur_out_next = current_set;
    pos_out_next = position;
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      bus_reg     <= step_pkg::BUS_IDLE;
      wait_reg    <= 1'b1;
      rdata_reg   <= 32'h0;
      ctrl_reg    <= step_pkg::CTRL_RESET;
      run_cur_reg <= step_pkg::RUN_CURRENT_RESET;
      on_reg      <= 1'b0;
      cur_out_reg <= 8'h00;
      pos_out_reg <= 32'h0;
    end else begin
      bus_reg     <= bus_next;
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      ctrl_reg    <= ctrl_next;
      run_cur_reg <= run_cur_next;
      on_reg      <= on_next;
      cur_out_reg <= cur_out_next;
      pos_out_reg <= pos_out_next;
    end
  end

  assign WAITREQUEST = wait_reg;
  assign READDATA    = rdata_reg;
  assign DRIVER_ON   = on_reg;
  assign CURRENT_SET = cur_out_reg;
  assign POSITION    = pos_out_reg;

endmodule
`default_nettype wire

// [inc/step_pkg.sv]
// Purpose: Shared constants and types for the step/direction command front end
// Assumes: 25 MHz core clock, 32-bit Avalon-MM register bus
// Notes:   Offsets are byte addresses of aligned words
package step_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned STEP_MIN_PW_NS  = 1500;
  // Least pulse width rounds up to whole cycles
  localparam int unsigned STEP_MIN_PW_CYC = (STEP_MIN_PW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned DIR_SETUP_NS    = 5000;
  localparam int unsigned DIR_SETUP_CYC   = (DIR_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned IDLE_DELAY_MS   = 100;
  localparam int unsigned IDLE_DELAY_CYC  = IDLE_DELAY_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS    = 4'h0;
  localparam logic [3:0] STATUS_OFS  = 4'h4;
  localparam logic [3:0] POS_OFS     = 4'h8;
  localparam logic [3:0] CURRENT_OFS = 4'hc;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_IDLE_BIT = 1;
  localparam int unsigned CTRL_RES_LSB  = 4;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0072;
  localparam logic [7:0]  RUN_CURRENT_RESET = 8'hff;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Microstep resolution
  // ----------------------------------------------------------------
  localparam int unsigned POS_W        = 32;
  localparam int unsigned RES_COUNT    = 16;
  localparam int unsigned FULL_RES_UPS = 51200;
  localparam logic [7:0]  IDLE_PCT     = 8'h3c;

  // Steps in finest units per edge; finest index gives one unit
  function automatic logic [15:0] step_increment(input logic [3:0] sel);
    case (sel)
      4'h0:    step_increment = 16'h0080;
      4'h1:    step_increment = 16'h0040;
      4'h2:    step_increment = 16'h0020;
      4'h3:    step_increment = 16'h0010;
      4'h4:    step_increment = 16'h0008;
      4'h5:    step_increment = 16'h0004;
      4'h6:    step_increment = 16'h0002;
      4'h7:    step_increment = 16'h0001;
      4'h8:    step_increment = 16'h0033;
      4'h9:    step_increment = 16'h001a;
      4'ha:    step_increment = 16'h000d;
      4'hb:    step_increment = 16'h000a;
      4'hc:    step_increment = 16'h0006;
      4'hd:    step_increment = 16'h0005;
      4'he:    step_increment = 16'h0003;
      default: step_increment = 16'h0001;
    endcase
  endfunction

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;

endpackage

// [inc/step_if.sv]
// Purpose: Carries synchronised step events from the input stage to the core
// Assumes: Single clock domain
// Notes:   Edge is a one-cycle pulse, direction a level
`timescale 1ns/1ns
`default_nettype none
interface step_if;
  logic edge_pulse;
  logic dir_level;
  logic enable_level;
  modport source (output edge_pulse, output dir_level, output enable_level);
  modport sink   (input edge_pulse, input dir_level, input enable_level);
endinterface
`default_nettype wire

// [logic/step_input_sync.sv]
// Purpose: Synchronises step, direction and enable pins and detects step edges
// Assumes: Pins may be asynchronous to CLOCK in practice
// Notes:   First synchroniser stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module step_input_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins
  input wire logic step_pin,
  input wire logic dir_pin,
  input wire logic enable_n_pin,
  // Towards the core
  step_if.source   ev
);

  logic [2:0] meta_reg;
  logic [2:0] meta_next;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       step_last_reg;
  logic       step_last_next;

  always_comb begin
    meta_next      = {enable_n_pin, dir_pin, step_pin};
    sync_next      = meta_reg;
    step_last_next = sync_reg[0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg      <= 3'h0;
      sync_reg      <= 3'h0;
      step_last_reg <= 1'b0;
    end else begin
      meta_reg      <= meta_next;
      sync_reg      <= sync_next;
      step_last_reg <= step_last_next;
    end
  end

  // Both edges count as a step
  assign ev.edge_pulse   = sync_reg[0] ^ step_last_reg;
  assign ev.dir_level    = sync_reg[1];
  // Open input reads low on the inverted pin, which enables
  assign ev.enable_level = ~sync_reg[2];

endmodule
`default_nettype wire

// [logic/step_position.sv]
// Purpose: Microstep position counter and idle-current setpoint
// Assumes: Step edges arrive no faster than the pin stage can resolve
// Notes:   Idle reduction applies only when enabled by software
`timescale 1ns/1ns
`default_nettype none
module step_position (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Step events
  step_if.sink                              ev,
  // Configuration
  input  wire logic                         sw_enable,
  input  wire logic                         idle_mode,
  input  wire logic [3:0]                   res_sel,
  input  wire logic [7:0]                   run_current,
  input  wire logic [31:0]                  idle_delay_cyc,
  // Results
  output logic [step_pkg::POS_W-1:0]        position,
  output logic [7:0]                        current_set,
  output logic                              driver_on,
  output logic                              idle_active,
  output logic [31:0]                       step_count
);

  logic [step_pkg::POS_W-1:0] pos_reg;
  logic [step_pkg::POS_W-1:0] pos_next;
  logic [31:0]                idle_cnt_reg;
  logic [31:0]                idle_cnt_next;
  logic                       idle_reg;
  logic                       idle_next;
  logic [7:0]                 cur_reg;
  logic [7:0]                 cur_next;
  logic [31:0]                steps_reg;
  logic [31:0]                steps_next;
  logic                       run_ok;
  logic [15:0]                reduced;

  always_comb begin
    run_ok        = sw_enable & ev.enable_level;
    pos_next      = pos_reg;
    steps_next    = steps_reg;
    idle_cnt_next = idle_cnt_reg;
    idle_next     = idle_reg;
    // Widened before the product so the full 16-bit result survives
    reduced       = (16'(run_current) * 16'(step_pkg::IDLE_PCT)) / 16'h0064;
    // Step commands are dropped while disabled
    if (run_ok && ev.edge_pulse) begin
      steps_next = steps_reg + 32'h1;
      // Direction sampled at the step edge
      if (ev.dir_level)
        pos_next = pos_reg + 32'(step_pkg::step_increment(res_sel));
      else
        pos_next = pos_reg - 32'(step_pkg::step_increment(res_sel));
      idle_cnt_next = 32'h0;
      idle_next     = 1'b0;
    end else if (idle_cnt_reg >= idle_delay_cyc) begin
      idle_next = 1'b1;
    end else begin
      idle_cnt_next = idle_cnt_reg + 32'h1;
    end
    // Idle drops the setpoint to 60 percent
    if (!run_ok)
      cur_next = 8'h00;
    else if (idle_mode && idle_reg)
      cur_next = reduced[7:0];
    else
      cur_next = run_current;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg      <= '0;
      idle_cnt_reg <= 32'h0;
      idle_reg     <= 1'b0;
      cur_reg      <= 8'h00;
      steps_reg    <= 32'h0;
    end else begin
      pos_reg      <= pos_next;
      idle_cnt_reg <= idle_cnt_next;
      idle_reg     <= idle_next;
      cur_reg      <= cur_next;
      steps_reg    <= steps_next;
    end
  end

  assign position    = pos_reg;
  assign current_set = cur_reg;
  assign driver_on   = run_ok;
  assign idle_active = idle_reg;
  assign step_count  = steps_reg;

endmodule
`default_nettype wire

// [sim/step_dir_input_props.sv]
// Purpose: Concurrent checks on the step/direction front end ports
// Assumes: Single clock, reset active low
// Notes:   Pin-to-position latency allowed a small window
`timescale 1ns/1ns
`default_nettype none
module step_dir_input_props #(
  parameter logic [31:0] IDLE_DELAY = 32'd20
) (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RSTN,
  // Command pins
  input wire logic        STEP_PULSE_IN,
  input wire logic        DIR_IN,
  input wire logic        DRIVE_ENABLE_IN_N,
  // Register bus
  input wire logic [3:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0]  BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  // Drive status
  input wire logic        DRIVER_ON,
  input wire logic [7:0]  CURRENT_SET,
  input wire logic [31:0] POSITION
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_pin_edge;
    $changed(STEP_PULSE_IN) && DRIVER_ON;
  endsequence
  sequence s_pos_move;
    ##[2:6] $changed(POSITION);
  endsequence
  a_step_moves_pos: assert property (s_pin_edge |-> s_pos_move)
    else $error("position did not follow a step edge");
  a_pos_needs_edge: assert property ($changed(POSITION) |->
    $past(STEP_PULSE_IN, 2) != $past(STEP_PULSE_IN, 6)) else $error("position moved without edge");
  a_dir_sense: assert property ($changed(POSITION) && DIR_IN == $past(DIR_IN, 8) |->
    ($signed(POSITION - $past(POSITION)) > 0) == DIR_IN) else $error("wrong step direction");
  a_pos_only_on: assert property ($changed(POSITION) |-> DRIVER_ON || $past(DRIVER_ON))
    else $error("position moved while disabled");
  a_pin_gate_off: assert property (DRIVE_ENABLE_IN_N [*6] |-> !DRIVER_ON)
    else $error("driver on with enable pin off");
  a_current_off: assert property (!DRIVER_ON [*3] |-> $past(CURRENT_SET) == 8'h00)
    else $error("current set while disabled");
  a_wait_stands: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_accept_has_req: assert property ($fell(WAITREQUEST) |-> $past(READ || WRITE))
    else $error("accept without request");
  a_req_answered: assert property ((READ || WRITE) && WAITREQUEST |-> ##[1:4] !WAITREQUEST)
    else $error("request not answered");
endmodule
bind step_dir_input step_dir_input_props #(.IDLE_DELAY(IDLE_DELAY)) step_dir_input_props_inst (
  .CLOCK(CLOCK), .RSTN(RSTN), .STEP_PULSE_IN(STEP_PULSE_IN), .DIR_IN(DIR_IN),
  .DRIVE_ENABLE_IN_N(DRIVE_ENABLE_IN_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .DRIVER_ON(DRIVER_ON), .CURRENT_SET(CURRENT_SET),
  .POSITION(POSITION)
);
`default_nettype wire

// [sim/motion_ctrl_model.sv]
// Purpose: Motion controller model driving step, direction and enable pins
// Assumes: Tasks are entered right after a rising clock edge
// Notes:   Enable lead is shortened in simulation to keep the run brief
`timescale 1ns/1ns
`default_nettype none
module motion_ctrl_model #(
  parameter int ENA_LEAD_CYC = 125000
) (
  // Clock
  input  wire logic clk,
  // Command pins
  output logic      step_pin,
  output logic      dir_pin,
  output logic      enable_n_pin
);
  // 40 cycles is 1.6 us, 130 cycles 5.2 us: both just past the limits
  localparam int PW_CYC    = 40;
  localparam int SETUP_CYC = 130;
  initial begin
    step_pin     = 1'b0;
    dir_pin      = 1'b1;
    enable_n_pin = 1'b0;
  end
  task automatic set_enable(input logic on);
    enable_n_pin <= ~on;
    repeat (ENA_LEAD_CYC) @(posedge clk);
  endtask
  task automatic step_edge(input logic dir);
    if (dir !== dir_pin) begin
      dir_pin <= dir;
      repeat (SETUP_CYC) @(posedge clk);
    end
    step_pin <= ~step_pin;
    repeat (PW_CYC) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [sim/step_direction_command_input_tb_top.sv]
// Purpose: Self-checking bench for the step/direction front end
// Assumes: Idle delay shortened to 20 cycles
// Notes:   Increments are 256 per microstep setting, rounded
`timescale 1ns/1ns
`default_nettype none
module step_direction_command_input_tb_top;
  typedef struct packed {
    logic [3:0] res;
    logic       dir;
    logic [7:0] inc;
  } row_t;
  logic        clock = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
  logic        step_pulse, dir, enable_n, waitrequest, driver_on;
  logic [3:0]  address = 4'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata, position, q, exp_pos;
  logic [7:0]  current_set;
  int          mismatches = 0, num_checks = 0, cycles = 0;
  row_t rows [16] = '{'{4'h0,1'b1,8'h80}, '{4'h1,1'b0,8'h40}, '{4'h2,1'b1,8'h20},
    '{4'h3,1'b0,8'h10}, '{4'h4,1'b1,8'h08}, '{4'h5,1'b0,8'h04}, '{4'h6,1'b1,8'h02},
    '{4'h7,1'b0,8'h01}, '{4'h8,1'b1,8'h33}, '{4'h9,1'b0,8'h1a}, '{4'ha,1'b1,8'h0d},
    '{4'hb,1'b0,8'h0a}, '{4'hc,1'b1,8'h06}, '{4'hd,1'b0,8'h05}, '{4'he,1'b1,8'h03},
    '{4'hf,1'b0,8'h01}};
  always #20 clock = ~clock;
  motion_ctrl_model #(.ENA_LEAD_CYC(50)) motion_ctrl_model_inst (
    .clk(clock), .step_pin(step_pulse), .dir_pin(dir), .enable_n_pin(enable_n));
  step_dir_input #(.IDLE_DELAY(32'd20)) step_dir_input_inst (
    .CLOCK(clock), .RSTN(rstn), .STEP_PULSE_IN(step_pulse), .DIR_IN(dir),
    .DRIVE_ENABLE_IN_N(enable_n), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .DRIVER_ON(driver_on), .CURRENT_SET(current_set),
    .POSITION(position));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Run length is some 3900 cycles; the ceiling leaves ample room
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    check("position", 32'h0, position);
    bus(1'b0, step_pkg::CTRL_OFS, 32'h0);
    check("ctrl", step_pkg::CTRL_RESET, q);
    bus(1'b0, 4'h3, 32'h0);
    check("unmapped", step_pkg::UNMAPPED_DATA, q);
    repeat (2) motion_ctrl_model_inst.step_edge(1'b1);
    check("position", 32'h0, position);
    motion_ctrl_model_inst.set_enable(1'b1);
    // Upper and reserved bits must be dropped by the control register
    bus(1'b1, step_pkg::CTRL_OFS, 32'hffff_ff7d);
    repeat (8) @(posedge clock);
    check("driver_on", 32'h1, {31'h0, driver_on});
    bus(1'b0, step_pkg::CTRL_OFS, 32'h0);
    check("ctrl", 32'h71, q);
    exp_pos = 32'h0;
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, step_pkg::CTRL_OFS, {24'h0, rows[i].res, 4'h1});
      exp_pos = rows[i].dir ? exp_pos + 2 * rows[i].inc : exp_pos - 2 * rows[i].inc;
      repeat (2) motion_ctrl_model_inst.step_edge(rows[i].dir);
      check("position", exp_pos, position);
    end
    bus(1'b0, step_pkg::POS_OFS, 32'h0);
    check("pos_reg", exp_pos, q);
    bus(1'b1, step_pkg::CURRENT_OFS, 32'hc8);
    // Lane 0 off: the run current must keep its value
    byteenable <= 4'he;
    bus(1'b1, step_pkg::CURRENT_OFS, 32'h11);
    byteenable <= 4'hf;
    bus(1'b1, step_pkg::CTRL_OFS, 32'h71);
    repeat (30) @(posedge clock);
    check("current_set", 32'hc8, {24'h0, current_set});
    bus(1'b1, step_pkg::CTRL_OFS, 32'h73);
    repeat (30) @(posedge clock);
    check("current_set", 32'h78, {24'h0, current_set});
    bus(1'b0, step_pkg::STATUS_OFS, 32'h0);
    check("status", 32'h5, q);
    fork
      motion_ctrl_model_inst.step_edge(1'b0);
      begin
        repeat (10) @(posedge clock);
        check("current_set", 32'hc8, {24'h0, current_set});
      end
    join
    exp_pos = exp_pos - 32'h1;
    check("position", exp_pos, position);
    motion_ctrl_model_inst.set_enable(1'b0);
    check("driver_on", 32'h0, {31'h0, driver_on});
    check("current_set", 32'h0, {24'h0, current_set});
    repeat (2) motion_ctrl_model_inst.step_edge(1'b1);
    check("position", exp_pos, position);
    motion_ctrl_model_inst.set_enable(1'b1);
    check("driver_on", 32'h1, {31'h0, driver_on});
    // Mid-run reset with the step pin left high
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    check("position", 32'h0, position);
    check("reset_outputs", 32'h0000_0200, {22'h0, waitrequest, driver_on, current_set});
    rstn <= 1'b1;
    bus(1'b0, step_pkg::CTRL_OFS, 32'h0);
    check("ctrl", step_pkg::CTRL_RESET, q);
    bus(1'b1, step_pkg::CTRL_OFS, 32'h71);
    repeat (8) @(posedge clock);
    check("position", 32'h0, position);
    finish_test();
  end
endmodule
`default_nettype wire
